// File: src/analog_input_alarm_monitor.sv
`timescale 1ns/1ps
// Contract
// - Hold full-scale value for 20 mA (default 100.0) and zero-scale for 4 mA (0.0).
// - Current mode when assigned to pacing or temperature; binary mode otherwise.
// - Binary mode compares against a split level, default 0.0.
// - Positive polarity: below split is 0, split and above is 1.
// - Negative polarity inverts the binary result.
// - Four input thresholds start empty; each set one raises an alarm in current mode.
// - High and high-high alarms rise when value exceeds threshold strictly.
// - Low and low-low alarms rise when value falls strictly below threshold.
// - High alarms hold until value drops below threshold minus hysteresis.
// - Low alarms hold until value rises above threshold plus hysteresis.
// - Probe has own four thresholds and hysteresis, all default 0.0.
// - Probe high alarms set above threshold, clear below threshold minus hysteresis.
// - Probe low alarms set below threshold, clear above threshold plus hysteresis.
module analog_input_alarm_monitor
	import aim_pkg::*;
#(
	parameter int VW = VAL_W,
	parameter int CW = CUR_W
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// loop current sample, microamps
	input wire logic [CW-1:0] LOOP_CURRENT,
	input wire logic LOOP_VALID,
	// temperature probe sample, tenths of a degree
	input wire logic signed [VW-1:0] TEMPERATURE_PROBE_INPUT,
	input wire logic TEMP_VALID,
	// configuration write: load pulse takes scaling, split, polarity, source and hysteresis; thresholds load on set bits, probe settings on TEMP_CFG_LOAD
	input wire logic CFG_LOAD,
	input wire logic [1:0] SOURCE_ASSIGN,
	input wire logic INPUT_POLARITY_SELECT,
	input wire logic signed [VW-1:0] FULL_SCALE_VALUE,
	input wire logic signed [VW-1:0] ZERO_SCALE_VALUE,
	input wire logic signed [VW-1:0] BINARY_SPLIT_LEVEL,
	input wire logic [3:0] AI_LEVEL_SET,
	input wire logic signed [VW-1:0] AI_HH_LEVEL,
	input wire logic signed [VW-1:0] AI_H_LEVEL,
	input wire logic signed [VW-1:0] AI_L_LEVEL,
	input wire logic signed [VW-1:0] AI_LL_LEVEL,
	input wire logic signed [VW-1:0] AI_HYST,
	input wire logic [3:0] AI_LEVEL_CLEAR,
	input wire logic TEMP_CFG_LOAD,
	input wire logic signed [VW-1:0] TEMP_HH_LEVEL,
	input wire logic signed [VW-1:0] TEMP_H_LEVEL,
	input wire logic signed [VW-1:0] TEMP_L_LEVEL,
	input wire logic signed [VW-1:0] TEMP_LL_LEVEL,
	input wire logic signed [VW-1:0] TEMP_HYST,
	// results
	output logic CURRENT_MODE,
	output logic signed [VW-1:0] PROCESS_VALUE,
	output logic PV_UPDATE,
	output logic BINARY_STATE,
	output logic [3:0] AI_ALARM,
	output logic [3:0] AI_LEVEL_VALID,
	output logic [3:0] TEMP_ALARM
);
	// settings, index 3..0 = high-high, high, low, low-low
	logic signed [VW-1:0] full_q;
	logic signed [VW-1:0] zero_q;
	logic signed [VW-1:0] split_q;
	logic pol_q;
	source_t src_q;
	logic signed [VW-1:0] ai_lvl_q [4];
	logic signed [VW-1:0] ai_hyst_q;
	logic [3:0] ai_set_q;
	logic signed [VW-1:0] t_lvl_q [4];
	logic signed [VW-1:0] t_hyst_q;
	logic signed [VW-1:0] ai_lvl_in [4];
	logic signed [VW-1:0] t_lvl_in [4];
	assign ai_lvl_in[3] = AI_HH_LEVEL;
	assign ai_lvl_in[2] = AI_H_LEVEL;
	assign ai_lvl_in[1] = AI_L_LEVEL;
	assign ai_lvl_in[0] = AI_LL_LEVEL;
	assign t_lvl_in[3] = TEMP_HH_LEVEL;
	assign t_lvl_in[2] = TEMP_H_LEVEL;
	assign t_lvl_in[1] = TEMP_L_LEVEL;
	assign t_lvl_in[0] = TEMP_LL_LEVEL;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			full_q <= FULL_SCALE_RST;
			zero_q <= ZERO_SCALE_RST;
			split_q <= SPLIT_RST;
			pol_q <= SIGN_POSITIVE;
			src_q <= SRC_OTHER;
			ai_hyst_q <= TEMP_SET_RST;
		end else if (CFG_LOAD) begin
			full_q <= FULL_SCALE_VALUE;
			zero_q <= ZERO_SCALE_VALUE;
			split_q <= BINARY_SPLIT_LEVEL;
			pol_q <= INPUT_POLARITY_SELECT;
			src_q <= source_t'(SOURCE_ASSIGN);
			ai_hyst_q <= AI_HYST;
		end
	end

	// threshold slots: a set bit writes and marks the slot configured, clear empties it
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ai_set_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				ai_lvl_q[i] <= TEMP_SET_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (AI_LEVEL_SET[i]) begin
					ai_lvl_q[i] <= ai_lvl_in[i];
					ai_set_q[i] <= 1'b1;
				end else if (AI_LEVEL_CLEAR[i]) begin
					ai_set_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			t_hyst_q <= TEMP_SET_RST;
			for (int i = 0; i < 4; i++) begin
				t_lvl_q[i] <= TEMP_SET_RST;
			end
		end else if (TEMP_CFG_LOAD) begin
			t_hyst_q <= TEMP_HYST;
			for (int i = 0; i < 4; i++) begin
				t_lvl_q[i] <= t_lvl_in[i];
			end
		end
	end

	// scaling pipeline; the divide by span is a constant so it maps to a multiplier-free quotient
	state_t st_q;
	logic [CW-1:0] cur_q;
	logic signed [2*VW+CW:0] prod_q;
	logic signed [CW:0] offs;
	logic signed [VW-1:0] pv_q;
	logic pv_upd_q;
	logic bin_q;
	logic is_current;
	assign is_current = (src_q == SRC_PACING) || (src_q == SRC_TEMP);
	assign offs = $signed({1'b0, cur_q}) - $signed({1'b0, CUR_ZERO_UA});

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= ST_IDLE;
			cur_q <= '0;
			prod_q <= '0;
			pv_q <= ZERO_SCALE_RST;
			pv_upd_q <= 1'b0;
		end else begin
			pv_upd_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (LOOP_VALID) begin
						cur_q <= LOOP_CURRENT;
						st_q <= ST_SCALE;
					end
				end
				ST_SCALE: begin
					prod_q <= (2*VW+CW+1)'(offs * (full_q - zero_q));
					st_q <= ST_CHECK;
				end
				ST_CHECK: begin
					pv_q <= VW'(zero_q + VW'(prod_q / $signed({1'b0, CUR_SPAN_UA})));
					pv_upd_q <= 1'b1;
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	chk_pv_latency: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(st_q == ST_IDLE && LOOP_VALID) |=> ##2 pv_upd_q) else $error("scaled value late");

	// binary view compares the scaled value with the split level
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			bin_q <= 1'b0;
		end else if (pv_upd_q) begin
			bin_q <= (pv_q >= split_q) ^ (pol_q != SIGN_POSITIVE);
		end
	end

	chk_binary_polarity: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(pv_upd_q && !CFG_LOAD) |=> (bin_q == (($past(pv_q) >= split_q) ^ pol_q))) else $error("binary state wrong");

	// input alarms only while in current mode and the slot is configured
	logic [3:0] ai_alarm;
	logic [3:0] t_alarm;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lim
			limit_alarm #(.W(VW), .IS_HIGH(g >= 2)) u_ai (
				.clk(CLK_SYS),
				.rst_n(RESETN),
				.eval(pv_upd_q),
				.enable(ai_set_q[g] && is_current),
				.value(pv_q),
				.level(ai_lvl_q[g]),
				.hyst(ai_hyst_q),
				.alarm_q(ai_alarm[g])
			);
			limit_alarm #(.W(VW), .IS_HIGH(g >= 2)) u_temp (
				.clk(CLK_SYS),
				.rst_n(RESETN),
				.eval(TEMP_VALID),
				.enable(1'b1),
				.value(TEMPERATURE_PROBE_INPUT),
				.level(t_lvl_q[g]),
				.hyst(t_hyst_q),
				.alarm_q(t_alarm[g])
			);
		end
	endgenerate

	chk_unset_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!ai_set_q[0]) |=> !ai_alarm[0]) else $error("alarm on empty threshold");
	chk_mode_gate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!is_current) |=> (ai_alarm == 4'h0)) else $error("input alarm outside current mode");

	assign CURRENT_MODE = is_current;
	assign PROCESS_VALUE = pv_q;
	assign PV_UPDATE = pv_upd_q;
	assign BINARY_STATE = bin_q;
	assign AI_ALARM = ai_alarm;
	assign AI_LEVEL_VALID = ai_set_q;
	assign TEMP_ALARM = t_alarm;
endmodule // analog_input_alarm_monitor

// File: src/aim_pkg.sv
package aim_pkg;
	// fixed point: values are signed, scaled by 10 (one decimal place)
	localparam int VAL_W = 24;
	localparam int CUR_W = 16;
	localparam logic signed [VAL_W-1:0] FULL_SCALE_RST = 24'sh0003E8;
	localparam logic signed [VAL_W-1:0] ZERO_SCALE_RST = 24'sh000000;
	localparam logic signed [VAL_W-1:0] SPLIT_RST = 24'sh000000;
	localparam logic signed [VAL_W-1:0] TEMP_SET_RST = 24'sh000000;
	// loop current in microamps
	localparam logic [CUR_W-1:0] CUR_ZERO_UA = 16'h0FA0;
	localparam logic [CUR_W-1:0] CUR_SPAN_UA = 16'h3E80;
	localparam logic SIGN_POSITIVE = 1'b0;
	typedef enum logic [1:0] {
		SRC_OTHER = 2'b00,
		SRC_PACING = 2'b01,
		SRC_TEMP = 2'b10,
		SRC_SPARE = 2'b11
	} source_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCALE = 2'b01,
		ST_CHECK = 2'b10
	} state_t;
endpackage

// File: src/limit_alarm.sv
`timescale 1ns/1ps
module limit_alarm
	import aim_pkg::*;
#(
	parameter int W = VAL_W,
	parameter bit IS_HIGH = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic eval,
	input wire logic enable,
	input wire logic signed [W-1:0] value,
	input wire logic signed [W-1:0] level,
	input wire logic signed [W-1:0] hyst,
	output logic alarm_q
);
	logic signed [W:0] v;
	logic signed [W:0] lv;
	logic signed [W:0] hv;
	logic signed [W:0] rel;
	logic set_c;
	logic clr_c;
	// explicit signed extension: a bare concatenation is unsigned and misorders negative readings
	assign v = $signed({value[W-1], value});
	assign lv = $signed({level[W-1], level});
	assign hv = $signed({hyst[W-1], hyst});
	assign rel = IS_HIGH ? (lv - hv) : (lv + hv);
	assign set_c = IS_HIGH ? (v > lv) : (v < lv);
	assign clr_c = IS_HIGH ? (v < rel) : (v > rel);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_q <= 1'b0;
		end else if (!enable) begin
			alarm_q <= 1'b0;
		end else if (eval) begin
			if (set_c) begin
				alarm_q <= 1'b1;
			end else if (clr_c) begin
				alarm_q <= 1'b0;
			end
		end
	end
	chk_alarm_sets: assert property (@(posedge clk) disable iff (!rst_n)
		(enable && eval && set_c) |=> alarm_q) else $error("alarm not set on crossing");
	chk_alarm_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(enable && eval && alarm_q && !clr_c) |=> alarm_q) else $error("alarm dropped inside hysteresis");
endmodule // limit_alarm

// File: tb/loop_front_end.sv
`timescale 1ns/1ps
module loop_front_end
	import aim_pkg::*;
(
	// clock
	input wire logic clk,
	// samples toward the monitor
	output logic [CUR_W-1:0] cur,
	output logic cur_valid,
	output logic signed [VAL_W-1:0] temp,
	output logic temp_valid
);
	// idle lines carry the inverse of the last sample, so a stale value never passes for a hold
	initial begin
		cur = '0;
		cur_valid = 1'b0;
		temp = '0;
		temp_valid = 1'b0;
	end
	task send_loop(input logic [CUR_W-1:0] ua);
		@(posedge clk);
		cur <= ua;
		cur_valid <= 1'b1;
		@(posedge clk);
		cur <= ~ua;
		cur_valid <= 1'b0;
	endtask
	task send_temp(input logic signed [VAL_W-1:0] t);
		@(posedge clk);
		temp <= t;
		temp_valid <= 1'b1;
		@(posedge clk);
		temp <= ~t;
		temp_valid <= 1'b0;
	endtask
endmodule // loop_front_end

// File: tb/analog_input_alarm_monitor_tb.sv
`timescale 1ns/1ps
module analog_input_alarm_monitor_tb;
	import aim_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_load = 1'b0;
	logic temp_load = 1'b0;
	logic pol = 1'b0;
	logic [1:0] src = 2'h0;
	logic [3:0] lvl_set = 4'h0;
	logic signed [VAL_W-1:0] split = '0;
	logic signed [VAL_W-1:0] full = 24'sh0003E8;
	logic signed [VAL_W-1:0] zero = 24'sh000000;
	logic signed [VAL_W-1:0] ai_hh = 24'sh000384;
	logic signed [VAL_W-1:0] ai_h = 24'sh0002BC;
	logic signed [VAL_W-1:0] ai_l = 24'sh00012C;
	logic signed [VAL_W-1:0] ai_ll = 24'sh000064;
	logic signed [VAL_W-1:0] ai_hyst = 24'sh000014;
	logic [3:0] lvl_clr = 4'h0;
	logic [CUR_W-1:0] lcur;
	logic lval, tval, cmode, pvu, bin;
	logic signed [VAL_W-1:0] tin, pv_out;
	logic [3:0] ai_al, ai_ok, t_al;
	int bad_count = 0;
	int checks_done = 0;
	always #2.5 clk = ~clk;
	loop_front_end fe (.clk(clk), .cur(lcur), .cur_valid(lval), .temp(tin), .temp_valid(tval));
	analog_input_alarm_monitor dut (.CLK_SYS(clk), .RESETN(rst_n), .LOOP_CURRENT(lcur), .LOOP_VALID(lval),
		.TEMPERATURE_PROBE_INPUT(tin), .TEMP_VALID(tval), .CFG_LOAD(cfg_load), .SOURCE_ASSIGN(src),
		.INPUT_POLARITY_SELECT(pol), .FULL_SCALE_VALUE(full), .ZERO_SCALE_VALUE(zero),
		.BINARY_SPLIT_LEVEL(split), .AI_LEVEL_SET(lvl_set), .AI_HH_LEVEL(ai_hh), .AI_H_LEVEL(ai_h),
		.AI_L_LEVEL(ai_l), .AI_LL_LEVEL(ai_ll), .AI_HYST(ai_hyst), .AI_LEVEL_CLEAR(lvl_clr),
		.TEMP_CFG_LOAD(temp_load), .TEMP_HH_LEVEL(24'sh0001F4), .TEMP_H_LEVEL(24'sh000190),
		.TEMP_L_LEVEL(24'sh000064), .TEMP_LL_LEVEL(24'sh000000), .TEMP_HYST(24'sh00000A), .CURRENT_MODE(cmode),
		.PROCESS_VALUE(pv_out), .PV_UPDATE(pvu), .BINARY_STATE(bin), .AI_ALARM(ai_al), .AI_LEVEL_VALID(ai_ok),
		.TEMP_ALARM(t_al));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	task cfg(input logic [1:0] s, input logic p);
		@(posedge clk);
		src <= s;
		pol <= p;
		split <= 24'sh0001F4;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		#1;
	endtask
	// the wait is bounded so a lost sample shows as a mismatch instead of a hang
	task raw(input logic [CUR_W-1:0] ua, input int e);
		int n;
		n = 0;
		fe.send_loop(ua);
		while (pvu !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(pv_out, e);
		@(posedge clk);
		#1;
	endtask
	task pv(input int v, input logic [3:0] a);
		raw(CUR_W'(CUR_ZERO_UA + v * 16), v);
		chk(ai_al, a);
	endtask
	task tmp(input int t, input logic [3:0] a);
		fe.send_temp(VAL_W'(t));
		@(posedge clk);
		#1;
		chk(t_al, a);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(cmode, 0);
		chk(ai_ok, 0);
		tmp(5, 4'hC);
		tmp(-5, 4'h3);
		pv(500, 4'h0);
		chk(bin, 1);
		$display("test defaults done");
		cfg(2'h3, 1'b0);
		chk(cmode, 0);
		pv(499, 4'h0);
		chk(bin, 0);
		pv(500, 4'h0);
		chk(bin, 1);
		cfg(2'h3, 1'b1);
		pv(499, 4'h0);
		chk(bin, 1);
		pv(500, 4'h0);
		chk(bin, 0);
		cfg(2'h1, 1'b0);
		chk(cmode, 1);
		cfg(2'h0, 1'b0);
		chk(cmode, 0);
		cfg(2'h2, 1'b0);
		chk(cmode, 1);
		$display("test binary done");
		pv(800, 4'h0);
		@(posedge clk);
		lvl_set <= 4'hF;
		@(posedge clk);
		lvl_set <= 4'h0;
		#1;
		chk(ai_ok, 4'hF);
		pv(800, 4'h4);
		pv(901, 4'hC);
		pv(900, 4'hC);
		pv(690, 4'h4);
		pv(679, 4'h0);
		pv(299, 4'h2);
		pv(99, 4'h3);
		pv(310, 4'h2);
		pv(321, 4'h0);
		cfg(2'h0, 1'b0);
		pv(901, 4'h0);
		cfg(2'h2, 1'b0);
		@(posedge clk);
		lvl_clr <= 4'hF;
		@(posedge clk);
		lvl_clr <= 4'h0;
		#1;
		chk(ai_ok, 4'h0);
		pv(99, 4'h0);
		@(posedge clk);
		full <= 24'sh0007D0;
		zero <= 24'shFFFC18;
		cfg(2'h2, 1'b0);
		raw(16'h4E20, 2000);
		raw(16'h0FA0, -1000);
		$display("test input alarms done");
		@(posedge clk);
		temp_load <= 1'b1;
		@(posedge clk);
		temp_load <= 1'b0;
		tmp(450, 4'h4);
		tmp(395, 4'h4);
		tmp(389, 4'h0);
		tmp(50, 4'h2);
		tmp(105, 4'h2);
		tmp(111, 4'h0);
		tmp(-1, 4'h3);
		tmp(501, 4'hC);
		$display("test probe alarms done");
		test_done();
	end
	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		test_done();
	end
endmodule // analog_input_alarm_monitor_tb
